// ==== rtl/auto_tuning_defines.vh ====
`ifndef AUTO_TUNING_DEFINES_VH
`define AUTO_TUNING_DEFINES_VH
// ****************************************
// Register map (byte addresses)
// ****************************************
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_RESULT      12'h008
`define REG_SYMBOL      12'h00C
`define REG_ENABLES     12'h010
`define REG_MEAS        12'h014
`define REG_REPORT      12'h018
// ****************************************
// Control fields
// ****************************************
`define CTRL_START      0
`define CTRL_FIXED      1
`define CTRL_SAVE       2
`define CTRL_MIR_LO     3
`define CTRL_MIR_HI     4
`define CTRL_ANGLE_LO   8
`define CTRL_ANGLE_HI   15
`define MIR_OSC         2'h0
`define MIR_ONESHOT     2'h1
`define MIR_STAT        2'h2
// ****************************************
// Tuning figures
// ****************************************
`define FOCUS_START_MM  16'h0014
`define FOCUS_STEP_MM   16'h0014
`define FOCUS_MAX_MM    16'h0190
`define FOCUS_FINE_MM   16'h0005
`define FOCUS_PEAK_OFS  16'h000A
`define FREQ_FOCUS_HZ   16'h01F4
`define FREQ_START_HZ   16'h012C
`define FREQ_STEP_HZ    16'h0064
`define FREQ_END_HZ     16'h0320
`define FREQ_VERIFY_HZ  16'h0032
`define SCANS_PER_BLOCK 8'h64
`define PEAK_SAMPLES    3'h5
`define QUAL_THRESH     8'h4B
`define ANGLE_TUNE      8'h32
`define MAX_RETRIES     2'h3
`define LAMP_MS         100
`define CLK_MHZ         125
`define LAMP_CYCLES     (`LAMP_MS * 1000 * `CLK_MHZ)
`define BEEP_SHORT      2'h1
`define BEEP_LONG       2'h2
// Report codes on the terminal line
`define MSG_STEP        3'h1
`define MSG_NOVALID     3'h2
`define MSG_MULTI       3'h3
`define MSG_CANCEL      3'h4
`define MSG_DONE        3'h5
`endif

// ==== rtl/scan_auto_tuning_sequencer.v ====
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "auto_tuning_defines.vh"
module scan_auto_tuning_sequencer #(
  parameter LAMP_CYCLES = `LAMP_CYCLES
) (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        extTrigger,
  output wire        readTrigger,
  input  wire        measDone,
  input  wire [7:0]  measQuality,
  input  wire [7:0]  measSymType,
  input  wire [7:0]  measSymLen,
  input  wire        measMulti,
  output reg         measStart,
  output reg  [15:0] focusMm,
  output reg  [15:0] scanFreqHz,
  output reg  [7:0]  mirrorAngle,
  output reg  [7:0]  scansPerBlock,
  output reg  [1:0]  internalParam,
  output reg         stdDecoder,
  output reg         readyLamp,
  output reg         resultLamp,
  output reg  [1:0]  beepCmd,
  output reg         beepStrobe,
  output reg         reportValid,
  output reg  [2:0]  reportCode,
  output reg  [15:0] reportParam,
  output reg  [7:0]  reportQual,
  output reg         nvSaveStrobe,
  output reg         tuningBusy
);
  // ****************************************
  // States
  // ****************************************
  localparam ST_IDLE   = 4'h0;
  localparam ST_FSWEEP = 4'h1;
  localparam ST_FPEAK  = 4'h2;
  localparam ST_FVER   = 4'h3;
  localparam ST_OTHER  = 4'h4;
  localparam ST_QSWEEP = 4'h5;
  localparam ST_QVLO   = 4'h6;
  localparam ST_QVHI   = 4'h7;
  localparam ST_OK     = 4'h8;
  localparam ST_FAIL   = 4'h9;
  localparam ST_WAIT   = 4'hA;
  localparam ST_BEEP2  = 4'hB;
  reg  [3:0]  state_r;
  reg  [3:0]  retState_r;
  reg         fixedFocus_r;
  reg  [1:0]  mirMode_r;
  reg  [7:0]  userAngle_r;
  reg  [15:0] workFreq_r;
  reg  [15:0] workFocus_r;
  reg  [7:0]  workType_r;
  reg  [7:0]  workLen_r;
  reg         filterOn_r;
  reg  [7:0]  bestQ_r;
  reg  [15:0] bestP_r;
  reg  [7:0]  symType_r;
  reg  [7:0]  symLen_r;
  reg         multiSeen_r;
  reg  [2:0]  sampleCnt_r;
  reg  [1:0]  retry_r;
  reg  [31:0] lampCnt_r;
  reg  [2:0]  failMsg_r;
  // ****************************************
  // APB slave, zero wait states
  // ****************************************
  wire apbWr = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  function [15:0] stepUp;
    input [15:0] v;
    input [15:0] s;
    begin
      stepUp = v + s;
    end
  endfunction
  always @* begin
    case (paddr)
      `REG_CTRL:    prdata = {16'h0000, userAngle_r, 3'h0, mirMode_r, 1'b0, fixedFocus_r, 1'b0};
      `REG_STATUS:  prdata = {24'h000000, failMsg_r, tuningBusy, state_r};
      `REG_RESULT:  prdata = {workFocus_r, workFreq_r};
      `REG_SYMBOL:  prdata = {16'h0000, workLen_r, workType_r};
      `REG_ENABLES: prdata = {31'h00000000, filterOn_r};
      `REG_MEAS:    prdata = {bestP_r, 8'h00, bestQ_r};
      default:      prdata = 32'h00000000;
    endcase
  end
  assign readTrigger = extTrigger && !tuningBusy;
  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r       <= ST_IDLE;
      retState_r    <= ST_IDLE;
      fixedFocus_r  <= 1'b0;
      mirMode_r     <= `MIR_OSC;
      userAngle_r   <= `ANGLE_TUNE;
      workFreq_r    <= `FREQ_FOCUS_HZ;
      workFocus_r   <= `FOCUS_START_MM;
      workType_r    <= 8'h00;
      workLen_r     <= 8'h00;
      filterOn_r    <= 1'b0;
      bestQ_r       <= 8'h00;
      bestP_r       <= 16'h0000;
      symType_r     <= 8'h00;
      symLen_r      <= 8'h00;
      multiSeen_r   <= 1'b0;
      sampleCnt_r   <= 3'h0;
      retry_r       <= 2'h0;
      lampCnt_r     <= 32'h00000000;
      failMsg_r     <= 3'h0;
      measStart     <= 1'b0;
      focusMm       <= `FOCUS_START_MM;
      scanFreqHz    <= `FREQ_FOCUS_HZ;
      mirrorAngle   <= `ANGLE_TUNE;
      scansPerBlock <= `SCANS_PER_BLOCK;
      internalParam <= 2'h0;
      stdDecoder    <= 1'b0;
      readyLamp     <= 1'b1;
      resultLamp    <= 1'b0;
      beepCmd       <= 2'h0;
      beepStrobe    <= 1'b0;
      reportValid   <= 1'b0;
      reportCode    <= 3'h0;
      reportParam   <= 16'h0000;
      reportQual    <= 8'h00;
      nvSaveStrobe  <= 1'b0;
      tuningBusy    <= 1'b0;
    end else begin
      measStart    <= 1'b0;
      beepStrobe   <= 1'b0;
      reportValid  <= 1'b0;
      nvSaveStrobe <= 1'b0;
      if (lampCnt_r != 32'h00000000) begin
        lampCnt_r <= lampCnt_r - 32'h00000001;
      end else begin
        resultLamp <= 1'b0;
      end
      // Host writes; config frozen while busy, no abort path
      if (apbWr && paddr == `REG_CTRL && !tuningBusy) begin
        fixedFocus_r <= pwdata[`CTRL_FIXED];
        mirMode_r    <= pwdata[`CTRL_MIR_HI:`CTRL_MIR_LO];
        userAngle_r  <= pwdata[`CTRL_ANGLE_HI:`CTRL_ANGLE_LO];
        if (pwdata[`CTRL_SAVE]) begin
          nvSaveStrobe <= 1'b1;
        end
      end
      if (apbWr && paddr == `REG_RESULT && !tuningBusy) begin
        workFocus_r <= pwdata[31:16];
        workFreq_r  <= pwdata[15:0];
      end
      if (!tuningBusy) begin
        mirrorAngle <= userAngle_r;
        focusMm     <= workFocus_r;
        scanFreqHz  <= workFreq_r;
      end
      if (measDone && (measMulti || multiSeen_r == 1'b0) && tuningBusy) begin
        multiSeen_r <= multiSeen_r | measMulti;
      end
      case (state_r)
        ST_IDLE: begin
          if (apbWr && paddr == `REG_CTRL && pwdata[`CTRL_START]) begin
            tuningBusy  <= 1'b1;
            readyLamp   <= 1'b0;
            stdDecoder  <= 1'b1;
            bestQ_r     <= 8'h00;
            bestP_r     <= 16'h0000;
            sampleCnt_r <= 3'h0;
            retry_r     <= 2'h0;
            multiSeen_r <= 1'b0;
            failMsg_r   <= 3'h0;
            internalParam <= 2'h0;
            scansPerBlock <= `SCANS_PER_BLOCK;
            if (pwdata[`CTRL_MIR_HI:`CTRL_MIR_LO] == `MIR_STAT) begin
              mirrorAngle <= pwdata[`CTRL_ANGLE_HI:`CTRL_ANGLE_LO];
            end else begin
              mirrorAngle <= `ANGLE_TUNE;
            end
            if (pwdata[`CTRL_FIXED]) begin
              scanFreqHz <= `FREQ_START_HZ;
              state_r    <= ST_QSWEEP;
            end else begin
              focusMm    <= `FOCUS_START_MM;
              scanFreqHz <= `FREQ_FOCUS_HZ;
              state_r    <= ST_FSWEEP;
            end
            measStart <= 1'b1;
          end
        end
        ST_FSWEEP: begin
          if (measDone) begin
            reportValid <= 1'b1;
            reportCode  <= `MSG_STEP;
            reportParam <= focusMm;
            reportQual  <= measQuality;
            if (measQuality > bestQ_r) begin
              bestQ_r   <= measQuality;
              bestP_r   <= focusMm;
              symType_r <= measSymType;
              symLen_r  <= measSymLen;
            end
            if (focusMm >= `FOCUS_MAX_MM) begin
              // Fine samples centred on best coarse focus
              focusMm <= (measQuality > bestQ_r ? focusMm : bestP_r) - `FOCUS_PEAK_OFS;
              sampleCnt_r <= 3'h0;
              state_r     <= ST_FPEAK;
            end else begin
              focusMm <= stepUp(focusMm, `FOCUS_STEP_MM);
            end
            measStart <= 1'b1;
          end
        end
        ST_FPEAK: begin
          if (measDone) begin
            reportValid <= 1'b1;
            reportCode  <= `MSG_STEP;
            reportParam <= focusMm;
            reportQual  <= measQuality;
            if (measQuality > bestQ_r) begin
              bestQ_r <= measQuality;
              bestP_r <= focusMm;
            end
            sampleCnt_r <= sampleCnt_r + 3'h1;
            if (sampleCnt_r == `PEAK_SAMPLES - 3'h1) begin
              focusMm <= (measQuality > bestQ_r) ? focusMm : bestP_r;
              state_r <= ST_FVER;
            end else begin
              focusMm <= stepUp(focusMm, `FOCUS_FINE_MM);
            end
            measStart <= 1'b1;
          end
        end
        ST_FVER, ST_OTHER: begin
          if (measDone) begin
            reportValid <= 1'b1;
            reportCode  <= `MSG_STEP;
            reportParam <= {14'h0000, internalParam};
            reportQual  <= measQuality;
            if (measQuality > `QUAL_THRESH) begin
              bestQ_r    <= 8'h00;
              scanFreqHz <= `FREQ_START_HZ;
              state_r    <= ST_QSWEEP;
              measStart  <= 1'b1;
            end else if (retry_r == `MAX_RETRIES) begin
              failMsg_r <= measMulti ? `MSG_MULTI : `MSG_NOVALID;
              state_r   <= ST_FAIL;
            end else begin
              retry_r       <= retry_r + 2'h1;
              internalParam <= internalParam + 2'h1;
              state_r       <= ST_OTHER;
              measStart     <= 1'b1;
            end
          end
        end
        ST_QSWEEP: begin
          if (measDone) begin
            reportValid <= 1'b1;
            reportCode  <= `MSG_STEP;
            reportParam <= scanFreqHz;
            reportQual  <= measQuality;
            if (measQuality > bestQ_r) begin
              bestQ_r   <= measQuality;
              bestP_r   <= scanFreqHz;
              symType_r <= measSymType;
              symLen_r  <= measSymLen;
            end
            if (scanFreqHz >= `FREQ_END_HZ) begin
              scanFreqHz <= (measQuality > bestQ_r ? scanFreqHz : bestP_r)
                            - `FREQ_VERIFY_HZ;
              state_r    <= ST_QVLO;
            end else begin
              scanFreqHz <= stepUp(scanFreqHz, `FREQ_STEP_HZ);
            end
            measStart <= 1'b1;
          end
        end
        ST_QVLO: begin
          if (measDone) begin
            reportValid <= 1'b1;
            reportCode  <= `MSG_STEP;
            reportParam <= scanFreqHz;
            reportQual  <= measQuality;
            scanFreqHz  <= stepUp(bestP_r, `FREQ_VERIFY_HZ);
            state_r     <= ST_QVHI;
            measStart   <= 1'b1;
          end
        end
        ST_QVHI: begin
          if (measDone) begin
            reportValid <= 1'b1;
            reportCode  <= `MSG_STEP;
            reportParam <= scanFreqHz;
            reportQual  <= measQuality;
            if (multiSeen_r || measMulti) begin
              failMsg_r <= `MSG_MULTI;
              state_r   <= ST_FAIL;
            end else if (bestQ_r <= `QUAL_THRESH) begin
              failMsg_r <= `MSG_NOVALID;
              state_r   <= ST_FAIL;
            end else begin
              state_r <= ST_OK;
            end
          end
        end
        ST_OK: begin
          workFreq_r <= bestP_r;
          if (!fixedFocus_r) begin
            workFocus_r <= focusMm;
          end
          workType_r  <= symType_r;
          workLen_r   <= symLen_r;
          filterOn_r  <= 1'b1;
          beepCmd     <= `BEEP_SHORT;
          beepStrobe  <= 1'b1;
          resultLamp  <= 1'b1;
          lampCnt_r   <= LAMP_CYCLES - 1;
          reportValid <= 1'b1;
          reportCode  <= `MSG_DONE;
          reportParam <= bestP_r;
          reportQual  <= bestQ_r;
          retState_r  <= ST_BEEP2;
          state_r     <= ST_WAIT;
        end
        ST_BEEP2: begin
          beepStrobe <= 1'b1;
          retState_r <= ST_IDLE;
          state_r    <= ST_WAIT;
        end
        ST_FAIL: begin
          beepCmd     <= `BEEP_LONG;
          beepStrobe  <= 1'b1;
          reportValid <= 1'b1;
          reportCode  <= failMsg_r;
          reportParam <= 16'h0000;
          reportQual  <= bestQ_r;
          retState_r  <= ST_IDLE;
          state_r     <= ST_WAIT;
          failMsg_r   <= `MSG_CANCEL;
        end
        ST_WAIT: begin
          if (failMsg_r == `MSG_CANCEL) begin
            reportValid <= 1'b1;
            reportCode  <= `MSG_CANCEL;
            failMsg_r   <= `MSG_NOVALID;
          end
          state_r <= retState_r;
          if (retState_r == ST_IDLE) begin
            tuningBusy <= 1'b0;
            stdDecoder <= 1'b0;
            readyLamp  <= 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== testbench/auto_tuning_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "auto_tuning_defines.vh"
module auto_tuning_chk #(
  parameter int LAMP_CYCLES = 10
) (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       extTrigger,
  input wire logic       readTrigger,
  input wire logic [7:0] scansPerBlock,
  input wire logic       stdDecoder,
  input wire logic       readyLamp,
  input wire logic       resultLamp,
  input wire logic [1:0] beepCmd,
  input wire logic       beepStrobe,
  input wire logic       reportValid,
  input wire logic [2:0] reportCode,
  input wire logic       tuningBusy
);
  // ****
  // Lamp on-time counter
  // ****
  logic [31:0] lampCnt_r;
  logic [31:0] lampCnt_nxt;
  assign lampCnt_nxt = resultLamp ? lampCnt_r + 32'h1 : 32'h0;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      lampCnt_r <= 32'h0;
    else
      lampCnt_r <= lampCnt_nxt;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ****
  // Properties
  // ****
  sequence s_short; beepStrobe && beepCmd == `BEEP_SHORT; endsequence
  sequence s_err; reportValid && (reportCode == `MSG_NOVALID || reportCode == `MSG_MULTI); endsequence
  sequence s_cancel; reportValid && reportCode == `MSG_CANCEL; endsequence
  property p_trigOff; tuningBusy |-> !readTrigger; endproperty
  property p_trigPass; !tuningBusy |-> readTrigger == extTrigger; endproperty
  property p_busyLamps; $past(tuningBusy) && tuningBusy |-> !readyLamp && stdDecoder; endproperty
  property p_readyBack; $fell(tuningBusy) |-> ##[0:1] (readyLamp && !stdDecoder); endproperty
  property p_block; tuningBusy |-> scansPerBlock == `SCANS_PER_BLOCK; endproperty
  property p_lampLen; $fell(resultLamp) |-> lampCnt_r == LAMP_CYCLES; endproperty
  property p_lampMax; resultLamp |-> lampCnt_r < LAMP_CYCLES; endproperty
  property p_twoBeeps; (beepStrobe && beepCmd == `BEEP_SHORT && !$past(beepStrobe, 2)) |-> ##2 s_short;
  endproperty
  property p_cancel; s_err |=> s_cancel; endproperty
  property p_longBeep; s_cancel |-> $past(beepStrobe) && $past(beepCmd) == `BEEP_LONG; endproperty
  a_trigOff: assert property (p_trigOff) else $error("trigger passed while busy");
  a_trigPass: assert property (p_trigPass) else $error("trigger blocked while idle");
  a_busyLamps: assert property (p_busyLamps) else $error("lamp or decoder wrong");
  a_readyBack: assert property (p_readyBack) else $error("ready not relit");
  a_block: assert property (p_block) else $error("block size wrong");
  a_lampLen: assert property (p_lampLen) else $error("lamp time wrong");
  a_lampMax: assert property (p_lampMax) else $error("lamp too long");
  a_twoBeeps: assert property (p_twoBeeps) else $error("second beep missing");
  a_cancel: assert property (p_cancel) else $error("cancel message missing");
  a_longBeep: assert property (p_longBeep) else $error("long beep missing");
endmodule
bind scan_auto_tuning_sequencer auto_tuning_chk #(.LAMP_CYCLES(LAMP_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .extTrigger(extTrigger), .readTrigger(readTrigger),
  .scansPerBlock(scansPerBlock), .stdDecoder(stdDecoder), .readyLamp(readyLamp),
  .resultLamp(resultLamp), .beepCmd(beepCmd), .beepStrobe(beepStrobe),
  .reportValid(reportValid), .reportCode(reportCode), .tuningBusy(tuningBusy));
`default_nettype wire

// ==== testbench/meas_front_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module meas_front_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        measStart,
  input  wire logic [15:0] focusMm,
  input  wire logic [15:0] scanFreqHz,
  input  wire logic [1:0]  scene,
  input  wire logic [3:0]  lag,
  output var  logic        measDone,
  output var  logic [7:0]  measQuality,
  output var  logic [7:0]  measSymType,
  output var  logic [7:0]  measSymLen,
  output var  logic        measMulti
);
  // ****
  // Scene: 0 one symbol, 1 none, 2 several, 3 focus-free optics
  // ****
  logic       pend_r;
  logic [3:0] waitCnt_r;
  logic [15:0] df;
  logic [15:0] dh;
  logic [15:0] loss;
  always_comb begin
    df = (focusMm > 16'h0078) ? focusMm - 16'h0078 : 16'h0078 - focusMm;
    dh = (scanFreqHz > 16'h0258) ? scanFreqHz - 16'h0258 : 16'h0258 - scanFreqHz;
    loss = dh / 16'h000A + ((scene == 2'h3) ? 16'h0000 : df);
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pend_r <= 1'b0;
      waitCnt_r <= 4'h0;
      measDone <= 1'b0;
      {measQuality, measSymType, measSymLen, measMulti} <= 25'h0;
    end else begin
      measDone <= 1'b0;
      {measQuality, measSymType, measSymLen, measMulti} <=
        ~{measQuality, measSymType, measSymLen, measMulti};
      if (measStart) begin
        pend_r <= 1'b1;
        waitCnt_r <= lag;
      end else if (pend_r && waitCnt_r != 4'h0) begin
        waitCnt_r <= waitCnt_r - 4'h1;
      end else if (pend_r) begin
        pend_r <= 1'b0;
        measDone <= 1'b1;
        measMulti <= (scene == 2'h2);
        measSymType <= (scene == 2'h1) ? 8'h00 : 8'h27;
        measSymLen <= (scene == 2'h1) ? 8'h00 : 8'h0A;
        measQuality <= (scene == 2'h1 || loss > 16'h0064) ? 8'h00 : 8'h64 - loss[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/scan_auto_tuning_sequencer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "auto_tuning_defines.vh"
module scan_auto_tuning_sequencer_bench;
  logic sys_clk, rstn, psel, penable, pwrite, extTrigger, pready, pslverr, readTrigger;
  logic measDone, measMulti, measStart, stdDecoder, readyLamp, resultLamp, beepStrobe;
  logic reportValid, nvSaveStrobe, tuningBusy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, res;
  logic [7:0] measQuality, measSymType, measSymLen, mirrorAngle, scansPerBlock, reportQual;
  logic [15:0] focusMm, scanFreqHz, reportParam, f0, q0, fMax;
  logic [1:0] internalParam, beepCmd, scene;
  logic [2:0] reportCode;
  logic [3:0] lag;
  logic [7:0] codes;
  logic lo, hi, lampOn, ipSeen;
  logic [15:0] rp0;
  logic [23:0] doneRep;
  int errors, samples_checked, nStarts, nShort, nLong, nStep, nSave;
  scan_auto_tuning_sequencer #(.LAMP_CYCLES(10)) u_dut (.sys_clk, .rstn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .extTrigger, .readTrigger,
    .measDone, .measQuality, .measSymType, .measSymLen, .measMulti, .measStart, .focusMm,
    .scanFreqHz, .mirrorAngle, .scansPerBlock, .internalParam, .stdDecoder, .readyLamp,
    .resultLamp, .beepCmd, .beepStrobe, .reportValid, .reportCode, .reportParam,
    .reportQual, .nvSaveStrobe, .tuningBusy);
  meas_front_model u_meas (.sys_clk, .rstn, .measStart, .focusMm, .scanFreqHz, .scene,
    .lag, .measDone, .measQuality, .measSymType, .measSymLen, .measMulti);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ****
  // Bus, compare and closing tasks
  // ****
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    chk("pslverr", 0, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****
  // Output monitor
  // ****
  always @(posedge sys_clk) begin
    if (measStart === 1'b1) begin
      if (nStarts == 0) {f0, q0} = {focusMm, scanFreqHz};
      if (scanFreqHz > fMax) fMax = scanFreqHz;
      lo |= (scanFreqHz === 16'h0226);
      hi |= (scanFreqHz === 16'h028A);
      nStarts++;
    end
    if (beepStrobe === 1'b1 && beepCmd === `BEEP_SHORT) nShort++;
    if (beepStrobe === 1'b1 && beepCmd === `BEEP_LONG) nLong++;
    if (reportValid === 1'b1) codes[reportCode] = 1'b1;
    if (reportValid === 1'b1 && reportCode === `MSG_STEP && nStep == 0) rp0 = reportParam;
    if (reportValid === 1'b1 && reportCode === `MSG_DONE) doneRep = {reportParam, reportQual};
    if (reportValid === 1'b1 && reportCode === `MSG_STEP) nStep++;
    if (nvSaveStrobe === 1'b1) nSave++;
    lampOn |= (resultLamp === 1'b1);
    ipSeen |= (tuningBusy === 1'b1 && internalParam !== 2'h0);
  end
  // One full run with busy-time checks and a refused rewrite of the control word
  task automatic run(input logic [31:0] ctrl, input logic [7:0] ang, input string nm);
    int n;
    {nStarts, nShort, nLong, nStep, nSave, fMax, codes, lo, hi, lampOn, ipSeen} = '0;
    apb(1'b1, `REG_CTRL, ctrl);
    n = 0;
    while (tuningBusy !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    apb(1'b1, `REG_CTRL, 32'h0000FF12);
    @(posedge sys_clk);
    chk("busy kept", 1, tuningBusy);
    chk("ready lamp", 0, readyLamp);
    chk("decoder", 1, stdDecoder);
    chk("trigger", 0, readTrigger);
    chk("angle", ang, mirrorAngle);
    n = 0;
    while (tuningBusy !== 1'b0 && n < 30000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (15) @(posedge sys_clk);
    chk("idle", 0, tuningBusy);
    chk("ready back", 1, readyLamp);
    chk("trigger back", 1, readTrigger);
    chk("no save", 0, nSave);
    apb(1'b0, `REG_RESULT, 32'h0);
    $display("test %s done", nm);
  endtask
  initial begin
    #600000;
    errors++;
    complete_run();
  end
  initial begin
    {rstn, psel, penable, pwrite, extTrigger, paddr, pwdata, scene, lag} = '0;
    {errors, samples_checked} = '0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk("reset focus", 16'h0014, focusMm);
    chk("reset freq", 16'h01F4, scanFreqHz);
    chk("reset ready", 1, readyLamp);
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmapped", 0, rd);
    $display("test reset done");
    lag <= 4'h3;
    extTrigger <= 1'b1;
    run(32'h00000001, 8'h32, "focus sweep");
    res = rd;
    chk("first focus", 16'h0014, f0);
    chk("first freq", 16'h01F4, q0);
    chk("top freq", 16'h0320, fMax);
    chk("verify band", 2'b11, {lo, hi});
    chk("beeps", 2, nShort);
    chk("lamp", 1, lampOn);
    chk("step lines", 1, nStep > 0);
    chk("first line", 16'h0014, rp0);
    chk("done line", 24'h025864, doneRep);
    chk("result", {16'h0078, 16'h0258}, res);
    apb(1'b0, `REG_SYMBOL, 32'h0);
    chk("symbol", 16'h0A27, rd[15:0]);
    apb(1'b0, `REG_ENABLES, 32'h0);
    chk("filter", 1, rd[0]);
    apb(1'b1, `REG_CTRL, 32'h00000004);
    repeat (3) @(posedge sys_clk);
    chk("save", 1, nSave);
    scene <= 2'h1;
    lag <= 4'h0;
    run(32'h00002109, 8'h32, "no symbol");
    chk("kept", res, rd);
    chk("long beep", 1, nLong);
    chk("codes", 8'h14, codes & 8'h1C);
    chk("no sweep", 16'h01F4, fMax);
    chk("other params", 1, ipSeen);
    scene <= 2'h2;
    run(32'h00000001, 8'h32, "several symbols");
    chk("kept", res, rd);
    chk("codes", 8'h18, codes & 8'h1C);
    scene <= 2'h3;
    run(32'h00002113, 8'h21, "fixed focus");
    chk("first freq", 16'h012C, q0);
    chk("top freq", 16'h0320, fMax);
    chk("freq", 16'h0258, rd[15:0]);
    chk("focus kept", 16'h0078, rd[31:16]);
    complete_run();
  end
endmodule
`default_nettype wire
